// ==== rtl/cpl_channel.sv ====
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module cpl_channel (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        link_clk_i,
  output logic             link_clk_o,
  output logic             link_clk_oe_o,
  input  wire logic [11:0] pix_i,
  output logic      [11:0] pix_o,
  output logic             pix_oe_o,
  input  wire logic        vref_n_i,
  output logic             vref_n_o,
  output logic             vref_n_oe_o,
  input  wire logic        href_n_i,
  output logic             href_n_o,
  output logic             href_n_oe_o,
  input  wire logic        bad_pixel_flag_n_i,
  output logic             bad_pixel_flag_n_o,
  output logic             bad_pixel_flag_n_oe_o,
  output logic             xcvr_drive_o,
  output logic             term_en_o
);

  localparam int unsigned PW = cpl_pkg::PTR_W;

  // ==========================================================================
  // control registers
  // ==========================================================================
  logic          dir_tx_q;
  logic          tx_en_q;
  logic          rx_en_q;
  logic [PW-1:0] img_size_q;
  logic          img_rdy_q;
  logic          ovfl_q;
  logic          img_done_p;
  logic          ovfl_p;

  logic wr_ctrl;
  logic wr_status;
  logic wr_size;
  logic wr_fifo;
  logic rd_fifo;

  assign wr_ctrl   = reg_wr_i && (reg_addr_i == cpl_pkg::OFS_CTRL);
  assign wr_status = reg_wr_i && (reg_addr_i == cpl_pkg::OFS_STATUS);
  assign wr_size   = reg_wr_i && (reg_addr_i == cpl_pkg::OFS_SIZE);
  assign wr_fifo   = reg_wr_i && (reg_addr_i == cpl_pkg::OFS_FIFO);
  assign rd_fifo   = reg_rd_i && (reg_addr_i == cpl_pkg::OFS_FIFO);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_tx_q   <= 1'b0;
      tx_en_q    <= 1'b0;
      rx_en_q    <= 1'b0;
      img_size_q <= '0;
    end else begin
      if (wr_ctrl) begin
        dir_tx_q <= reg_wdata_i[cpl_pkg::CTRL_DIR_TX];
        tx_en_q  <= reg_wdata_i[cpl_pkg::CTRL_TX_EN];
        rx_en_q  <= reg_wdata_i[cpl_pkg::CTRL_RX_EN];
      end
      if (wr_size) begin
        img_size_q <= reg_wdata_i[PW-1:0];
      end
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      img_rdy_q <= 1'b0;
      ovfl_q    <= 1'b0;
    end else begin
      if (img_done_p) begin
        img_rdy_q <= 1'b1;
      end else if (wr_status && reg_wdata_i[cpl_pkg::ST_IMG_RDY]) begin
        img_rdy_q <= 1'b0;
      end
      if (ovfl_p) begin
        ovfl_q <= 1'b1;
      end else if (wr_status && reg_wdata_i[cpl_pkg::ST_OVFL]) begin
        ovfl_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // channel storage: host, state machine and bulk stages as one ring
  // ==========================================================================
  logic [31:0]   mem_q [cpl_pkg::RX_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] count_q;
  logic [PW-1:0] cap;
  logic          empty;
  logic          full;
  logic          push;
  logic          pop;
  logic [31:0]   push_data;
  logic [31:0]   rx_word;
  logic          rx_push;
  logic          tx_pop;

  // rx mode keeps the four extra pipeline words
  assign cap   = dir_tx_q ? cpl_pkg::TX_CAP : cpl_pkg::RX_CAP;
  assign empty = (count_q == '0);
  assign full  = (count_q >= cap);

  // bulk store is routed to whichever direction is selected
  assign push = dir_tx_q ? (wr_fifo && !full) : (rx_push && !full);
  assign pop  = dir_tx_q ? tx_pop : (rd_fifo && !empty);
  assign push_data = dir_tx_q ? reg_wdata_i : rx_word;
  assign ovfl_p = (dir_tx_q ? wr_fifo : rx_push) && full;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (wr_ctrl &&
                 (reg_wdata_i[cpl_pkg::CTRL_DIR_TX] != dir_tx_q)) begin
      // changing direction discards stale contents
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == cpl_pkg::PTR_TOP) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == cpl_pkg::PTR_TOP) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + PW'(push) - PW'(pop);
    end
  end

  // ==========================================================================
  // register read port
  // ==========================================================================
  logic tx_busy_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        cpl_pkg::OFS_CTRL:
          reg_rdata_o <= {29'h0, rx_en_q, tx_en_q, dir_tx_q};
        cpl_pkg::OFS_STATUS:
          reg_rdata_o <= {27'h0, full, empty, tx_busy_q, ovfl_q, img_rdy_q};
        cpl_pkg::OFS_SIZE:
          reg_rdata_o <= {14'h0, img_size_q};
        cpl_pkg::OFS_FIFO:
          reg_rdata_o <= (!dir_tx_q && !empty) ? mem_q[rd_ptr_q] : '0;
        cpl_pkg::OFS_COUNT:
          reg_rdata_o <= {14'h0, count_q};
        default:
          reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ==========================================================================
  // link input synchronisers
  // ==========================================================================
  logic [15:0] in_s1_q;
  logic [15:0] in_s2_q;
  logic        clk_s3_q;
  logic        link_rise;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_s1_q  <= 16'hffff;
      in_s2_q  <= 16'hffff;
      clk_s3_q <= 1'b1;
    end else begin
      in_s1_q  <= {link_clk_i, vref_n_i, href_n_i, bad_pixel_flag_n_i, pix_i};
      in_s2_q  <= in_s1_q;
      clk_s3_q <= in_s2_q[cpl_pkg::HW_CE];
    end
  end

  assign link_rise = in_s2_q[cpl_pkg::HW_CE] && !clk_s3_q;

  // ==========================================================================
  // receiver
  // ==========================================================================
  typedef enum logic [0:0] {CPL_RX_SEEK, CPL_RX_CAP} cpl_rx_st_t;
  cpl_rx_st_t    rx_st_q;
  logic          rx_hi_q;
  logic [15:0]   rx_lo_q;
  logic [PW-1:0] rx_words_q;
  logic [15:0]   rx_hw;
  logic          rx_go;
  logic          rx_take;

  // stored clock-enable bit marks a captured sample
  assign rx_hw = {1'b1, in_s2_q[14:0]};
  assign rx_go = rx_en_q && !dir_tx_q && (img_size_q != '0);
  // frame reference low marks row 0 column 0
  assign rx_take = link_rise && rx_go &&
                   ((rx_st_q == CPL_RX_CAP) ||
                    !in_s2_q[cpl_pkg::HW_VREF]);
  assign rx_push = rx_take && rx_hi_q;
  assign rx_word = {rx_hw, rx_lo_q};
  assign img_done_p = rx_push && (rx_words_q + 1'b1 == img_size_q);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_q    <= CPL_RX_SEEK;
      rx_hi_q    <= 1'b0;
      rx_lo_q    <= '0;
      rx_words_q <= '0;
    end else if (!rx_go) begin
      rx_st_q    <= CPL_RX_SEEK;
      rx_hi_q    <= 1'b0;
      rx_words_q <= '0;
    end else if (rx_take) begin
      rx_hi_q <= !rx_hi_q;
      if (!rx_hi_q) begin
        rx_lo_q <= rx_hw;
      end
      unique case (rx_st_q)
        CPL_RX_SEEK: begin
          rx_st_q    <= CPL_RX_CAP;
          rx_words_q <= '0;
        end
        CPL_RX_CAP: begin
          if (rx_push) begin
            if (img_done_p) begin
              rx_st_q    <= CPL_RX_SEEK;
              rx_words_q <= '0;
            end else begin
              rx_words_q <= rx_words_q + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // transmitter
  // ==========================================================================
  typedef enum logic [0:0] {CPL_TX_IDLE, CPL_TX_SEND} cpl_tx_st_t;
  cpl_tx_st_t    tx_st_q;
  logic [7:0]    tx_ph_q;
  logic          tx_hi_q;
  logic [PW-1:0] tx_words_q;
  logic [15:0]   tx_hw_q;
  logic [15:0]   tx_next_hw;
  logic          tx_pix_end;
  logic          tx_img_end;
  logic          tx_start;

  assign tx_next_hw = tx_hi_q ? mem_q[rd_ptr_q][31:16]
                              : mem_q[rd_ptr_q][15:0];
  assign tx_pix_end = (tx_st_q == CPL_TX_SEND) &&
                      (tx_ph_q == cpl_pkg::PIX_LAST);
  assign tx_pop     = tx_pix_end && tx_hi_q;
  assign tx_img_end = tx_pop && (tx_words_q + 1'b1 == img_size_q);
  // a whole image must be stored before the first one goes out
  assign tx_start   = dir_tx_q && tx_en_q && (img_size_q != '0) &&
                      (count_q >= img_size_q);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_q    <= CPL_TX_IDLE;
      tx_ph_q    <= '0;
      tx_hi_q    <= 1'b0;
      tx_words_q <= '0;
      tx_hw_q    <= cpl_pkg::IDLE_HW;
      tx_busy_q  <= 1'b0;
    end else begin
      unique case (tx_st_q)
        CPL_TX_IDLE: begin
          tx_hw_q   <= cpl_pkg::IDLE_HW;
          tx_busy_q <= 1'b0;
          if (tx_start) begin
            tx_st_q    <= CPL_TX_SEND;
            tx_ph_q    <= '0;
            tx_hi_q    <= 1'b0;
            tx_words_q <= '0;
            tx_busy_q  <= 1'b1;
          end
        end
        CPL_TX_SEND: begin
          if (tx_ph_q == '0) begin
            tx_hw_q <= tx_next_hw;
          end
          if (tx_pix_end) begin
            tx_ph_q <= '0;
            tx_hi_q <= !tx_hi_q;
            if (tx_pop) begin
              tx_words_q <= tx_img_end ? '0 : tx_words_q + 1'b1;
            end
            // back to back unless disabled or empty at the boundary
            if ((tx_img_end && (!tx_en_q || (count_q == PW'(1)))) ||
                (tx_pop && !tx_img_end && (count_q == PW'(1))) ||
                !dir_tx_q) begin
              tx_st_q <= CPL_TX_IDLE;
              tx_hw_q <= cpl_pkg::IDLE_HW;
            end
          end else begin
            tx_ph_q <= tx_ph_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // link outputs
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_clk_o         <= 1'b1;
      pix_o              <= 12'hfff;
      vref_n_o           <= 1'b1;
      href_n_o           <= 1'b1;
      bad_pixel_flag_n_o <= 1'b1;
    end else begin
      // clock low for three cycles from the pixel start, rising before mid-pixel when enabled
      link_clk_o <= !(tx_busy_q && tx_hw_q[cpl_pkg::HW_CE] &&
                      (tx_ph_q < cpl_pkg::HALF_CNT) &&
                      (tx_st_q == CPL_TX_SEND) && (tx_ph_q != '0));
      pix_o              <= tx_hw_q[cpl_pkg::PIX_W-1:0];
      vref_n_o           <= tx_hw_q[cpl_pkg::HW_VREF];
      href_n_o           <= tx_hw_q[cpl_pkg::HW_HREF];
      bad_pixel_flag_n_o <= tx_hw_q[cpl_pkg::HW_BAD];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xcvr_drive_o          <= 1'b0;
      term_en_o             <= 1'b1;
      link_clk_oe_o         <= 1'b0;
      pix_oe_o              <= 1'b0;
      vref_n_oe_o           <= 1'b0;
      href_n_oe_o           <= 1'b0;
      bad_pixel_flag_n_oe_o <= 1'b0;
    end else begin
      xcvr_drive_o          <= dir_tx_q;
      term_en_o             <= !dir_tx_q;
      link_clk_oe_o         <= dir_tx_q;
      pix_oe_o              <= dir_tx_q;
      vref_n_oe_o           <= dir_tx_q;
      href_n_oe_o           <= dir_tx_q;
      bad_pixel_flag_n_oe_o <= dir_tx_q;
    end
  end

endmodule : cpl_channel

// ==== rtl/cpl_pkg.sv ====
package cpl_pkg;

  // ==========================================================================
  // register bus
  // ==========================================================================
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_SIZE   = 8'h08;
  localparam logic [7:0]  OFS_FIFO   = 8'h0c;
  localparam logic [7:0]  OFS_COUNT  = 8'h10;

  // control fields
  localparam int unsigned CTRL_DIR_TX = 0;
  localparam int unsigned CTRL_TX_EN  = 1;
  localparam int unsigned CTRL_RX_EN  = 2;
  // status fields
  localparam int unsigned ST_IMG_RDY  = 0;
  localparam int unsigned ST_OVFL     = 1;
  localparam int unsigned ST_TX_BUSY  = 2;
  localparam int unsigned ST_EMPTY    = 3;
  localparam int unsigned ST_FULL     = 4;

  // ==========================================================================
  // storage
  // ==========================================================================
  localparam int unsigned HOST_DEPTH = 4096;
  localparam int unsigned SM_DEPTH   = 1024;
  localparam int unsigned BULK_DEPTH = 131072;
  localparam int unsigned RX_EXTRA   = 4;
  localparam int unsigned PIX_PER_WORD = 2;
  localparam int unsigned TX_DEPTH   = HOST_DEPTH + SM_DEPTH + BULK_DEPTH;
  localparam int unsigned RX_DEPTH   = TX_DEPTH + RX_EXTRA;
  localparam int unsigned PTR_W      = 18;
  localparam logic [PTR_W-1:0] TX_CAP  = PTR_W'(TX_DEPTH);
  localparam logic [PTR_W-1:0] RX_CAP  = PTR_W'(RX_DEPTH);
  localparam logic [PTR_W-1:0] PTR_TOP = PTR_W'(RX_DEPTH - 1);

  // ==========================================================================
  // halfword layout
  // ==========================================================================
  localparam int unsigned PIX_W   = 12;
  localparam int unsigned HW_W    = 16;
  localparam int unsigned HW_CE   = 15;
  localparam int unsigned HW_VREF = 14;
  localparam int unsigned HW_HREF = 13;
  localparam int unsigned HW_BAD  = 12;
  localparam logic [15:0] IDLE_HW = 16'hffff;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LINK_HALF_NS  = 160;
  localparam int unsigned HALF_CYC_RAW  = LINK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam logic [7:0]  HALF_CNT  = 8'(HALF_CYC);
  localparam logic [7:0]  PIX_LAST  = 8'(2 * HALF_CYC - 1);

endpackage : cpl_pkg

// ==== verif/cpl_channel_checker.sv ====
`timescale 1ns/10ps
module cpl_channel_checker (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        link_clk_o,
  input wire logic        link_clk_oe_o,
  input wire logic [11:0] pix_o,
  input wire logic        pix_oe_o,
  input wire logic        vref_n_o,
  input wire logic        vref_n_oe_o,
  input wire logic        href_n_o,
  input wire logic        href_n_oe_o,
  input wire logic        bad_pixel_flag_n_o,
  input wire logic        bad_pixel_flag_n_oe_o,
  input wire logic        xcvr_drive_o,
  input wire logic        term_en_o
);
  // ==========================
  // link sequences
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence low_half_s;
    !link_clk_o [*3] ##1 link_clk_o;
  endsequence
  sequence lines_still_s;
    $stable({pix_o, vref_n_o, href_n_o, bad_pixel_flag_n_o}) [*2];
  endsequence
  // ==========================
  // assertions
  oe_match_a: assert property (
    link_clk_oe_o == xcvr_drive_o && pix_oe_o == xcvr_drive_o)
    else $error("link enable differs from drive");
  ref_oe_a: assert property (
    vref_n_oe_o == xcvr_drive_o && href_n_oe_o == xcvr_drive_o &&
    bad_pixel_flag_n_oe_o == xcvr_drive_o)
    else $error("reference enable differs from drive");
  term_dir_a: assert property (term_en_o != xcvr_drive_o)
    else $error("termination not opposite to drive");
  idle_high_a: assert property (!xcvr_drive_o |->
    link_clk_o && (&pix_o) && vref_n_o && href_n_o && bad_pixel_flag_n_o)
    else $error("link output low in receive mode");
  rd_quiet_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data without read");
  unmapped_rd_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h14 |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  clk_half_a: assert property ($fell(link_clk_o) |-> low_half_s)
    else $error("link clock low phase wrong");
  data_setup_a: assert property (
    $rose(link_clk_o) |-> lines_still_s)
    else $error("link data moves at clock rise");
endmodule : cpl_channel_checker

bind cpl_channel cpl_channel_checker i_cpl_channel_checker (
  .clk_sys_i, .arst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
  .link_clk_o, .link_clk_oe_o, .pix_o, .pix_oe_o, .vref_n_o,
  .vref_n_oe_o, .href_n_o, .href_n_oe_o, .bad_pixel_flag_n_o,
  .bad_pixel_flag_n_oe_o, .xcvr_drive_o, .term_en_o);

// ==== verif/cpl_img_src.sv ====
`timescale 1ns/10ps
module cpl_img_src (
  output logic        link_clk_o,
  output logic [11:0] pix_o,
  output logic        vref_n_o,
  output logic        href_n_o,
  output logic        bad_pixel_flag_n_o
);
  logic [15:0] last_q = 16'hffff;
  initial begin
    link_clk_o = 1'b1;
    {vref_n_o, href_n_o, bad_pixel_flag_n_o, pix_o} = 15'h7fff;
  end
  // ==========================
  // one pixel per 320 ns, no flow control
  task automatic send_pix(input logic [15:0] hw);
    // keep every change off the system clock edge
    #5;
    link_clk_o = 1'b0;
    {vref_n_o, href_n_o, bad_pixel_flag_n_o, pix_o} = hw[14:0];
    last_q = hw;
    #160;
    link_clk_o = 1'b1;
    #155;
  endtask : send_pix
  // clock stands still, lines no longer hold data
  task automatic end_frame();
    {vref_n_o, href_n_o, bad_pixel_flag_n_o, pix_o} = ~last_q[14:0];
  endtask : end_frame
endmodule : cpl_img_src

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  wire         link_clk_i, vref_n_i, href_n_i, bad_pixel_flag_n_i;
  wire  [11:0] pix_i, s_pix;
  wire         s_clk, s_vref, s_href, s_bad;
  logic        link_clk_o, link_clk_oe_o, pix_oe_o, vref_n_o, vref_n_oe_o;
  logic        href_n_o, href_n_oe_o, bad_pixel_flag_n_o;
  logic        bad_pixel_flag_n_oe_o, xcvr_drive_o, term_en_o;
  logic [11:0] pix_o;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [32:0] exp_q [$];
  logic [14:0] tx_q [$];
  logic [31:0] got = 32'h0;
  logic        rd_d = 1'b0;
  logic        lclk_d = 1'b1;

  initial forever #20 clk_sys_i = ~clk_sys_i;
  assign link_clk_i = link_clk_oe_o ? link_clk_o : s_clk;
  assign pix_i = pix_oe_o ? pix_o : s_pix;
  assign vref_n_i = vref_n_oe_o ? vref_n_o : s_vref;
  assign href_n_i = href_n_oe_o ? href_n_o : s_href;
  assign bad_pixel_flag_n_i = bad_pixel_flag_n_oe_o ? bad_pixel_flag_n_o
                                                    : s_bad;
  cpl_channel i_cpl_channel (.clk_sys_i, .arst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_clk_i,
    .link_clk_o, .link_clk_oe_o, .pix_i, .pix_o, .pix_oe_o, .vref_n_i,
    .vref_n_o, .vref_n_oe_o, .href_n_i, .href_n_o, .href_n_oe_o,
    .bad_pixel_flag_n_i, .bad_pixel_flag_n_o, .bad_pixel_flag_n_oe_o,
    .xcvr_drive_o, .term_en_o);
  cpl_img_src i_cpl_img_src (.link_clk_o(s_clk), .pix_o(s_pix),
    .vref_n_o(s_vref), .href_n_o(s_href), .bad_pixel_flag_n_o(s_bad));

  // ==========================
  // tasks
  task automatic close_out();
    $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic stall();
    n_mismatch++;
    $display("unexpected wait timed out");
    close_out();
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e);
    exp_q.push_back({c, e});
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    @(posedge clk_sys_i);
    got = reg_rdata_o;
  endtask : rd

  // ==========================
  // result watcher
  always @(posedge clk_sys_i) begin : watch
    logic [32:0] n;
    logic [14:0] t;
    logic [14:0] o;
    rd_d   <= reg_rd_i;
    lclk_d <= link_clk_o;
    if (rd_d && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      if (n[32]) `CHK("rdata", n[31:0], reg_rdata_o)
    end
    if (link_clk_o && !lclk_d && xcvr_drive_o) begin
      `CHK("tx due", 1'b1, tx_q.size() > 0)
      if (tx_q.size() > 0) begin
        t = tx_q.pop_front();
        o = {vref_n_o, href_n_o, bad_pixel_flag_n_o, pix_o};
        `CHK("tx halfword", t, o)
      end
    end
  end

  // ==========================
  // main sequence
  initial begin : main
    logic [31:0] w [2];
    logic [15:0] hw [6];
    int k;
    logic [15:0] idl;
    void'($urandom(32'h053f));
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(cpl_pkg::OFS_CTRL, 1'b1, 32'h0);
    rd(cpl_pkg::OFS_STATUS, 1'b1, 32'h8);
    wr(8'h14, $urandom);
    rd(8'h14, 1'b1, 32'h0);
    `CHK("term", 1'b1, term_en_o)
    $display("test reset done");
    wr(cpl_pkg::OFS_CTRL, 32'h1);
    wr(cpl_pkg::OFS_SIZE, 32'h2);
    for (k = 0; k < 2; k++) w[k] = $urandom | 32'h8000_8000;
    wr(cpl_pkg::OFS_FIFO, w[0]);
    wr(cpl_pkg::OFS_CTRL, 32'h3);
    repeat (40) @(posedge clk_sys_i);
    rd(cpl_pkg::OFS_COUNT, 1'b1, 32'h1);
    for (k = 0; k < 2; k++) begin
      tx_q.push_back(w[k][14:0]);
      tx_q.push_back(w[k][30:16]);
    end
    wr(cpl_pkg::OFS_FIFO, w[1]);
    for (k = 0; k < 400 && tx_q.size() > 0; k++) @(posedge clk_sys_i);
    if (tx_q.size() > 0) stall();
    repeat (16) @(posedge clk_sys_i);
    idl = {link_clk_o, vref_n_o, href_n_o, bad_pixel_flag_n_o, pix_o};
    `CHK("idle", 16'hffff, idl)
    rd(cpl_pkg::OFS_COUNT, 1'b1, 32'h0);
    $display("test transmit done");
    wr(cpl_pkg::OFS_CTRL, 32'h4);
    repeat (4) @(posedge clk_sys_i);
    `CHK("rx drive", 1'b0, xcvr_drive_o)
    for (k = 0; k < 6; k++) begin
      hw[k] = {1'b1, k != 2, 14'($urandom)};
      i_cpl_img_src.send_pix(hw[k]);
    end
    i_cpl_img_src.end_frame();
    got = 32'h0;
    for (k = 0; k < 40 && got[0] !== 1'b1; k++)
      rd(cpl_pkg::OFS_STATUS, 1'b0, 32'h0);
    if (got[0] !== 1'b1) stall();
    rd(cpl_pkg::OFS_COUNT, 1'b1, 32'h2);
    rd(cpl_pkg::OFS_FIFO, 1'b1, {hw[3], hw[2]});
    rd(cpl_pkg::OFS_FIFO, 1'b1, {hw[5], hw[4]});
    wr(cpl_pkg::OFS_STATUS, 32'h1);
    rd(cpl_pkg::OFS_STATUS, 1'b1, 32'h8);
    $display("test receive done");
    close_out();
  end
endmodule : testbench
